/* rtl/abm_regs.svh */
/*
 constants of the bus master job interpreter: register offsets, job codes,
 job byte positions, flag bits and reset values.
 assumes byte addresses on a 32-bit avalon slave, one register per word.
*/
// Operation
// - configuration job refused in protected mode
// - flag byte one bit3 selects start-up mode
// - flag byte two bit3 enables automatic addressing
// - other flag bits ignored, never altered
// - only changed parameters are sent to slaves by the parameter write job
// - echo of every parameter transfer stored per slave
// - echo job returns all echoes at once
// - newest echo overwrites older echo
// - configuration job data stored as desired configuration
// - permanent parameters sent to slaves on start-up
`ifndef ABM_REGS_SVH
`define ABM_REGS_SVH

// register byte offsets
`define ABM_REG_CTRL   12'h000
`define ABM_REG_STAT   12'h004
`define ABM_REG_LIST   12'h008
`define ABM_REG_CODE   12'h00C
`define ABM_PAGE_SBUF  4'h1
`define ABM_PAGE_RBUF  4'h2
`define ABM_PAGE_CFG   4'h3

// job codes in byte zero
`define ABM_CODE_CFG   8'h1A
`define ABM_CODE_WPAR  8'h1C
`define ABM_CODE_ECHO  8'h13

// job byte positions
`define ABM_CFG_LIST0  6'd2
`define ABM_CFG_LIST3  6'd5
`define ABM_CFG_ID0    6'd6
`define ABM_CFG_ID31   6'd37
`define ABM_CFG_PAR0   6'd38
`define ABM_CFG_PAR15  6'd53
`define ABM_CFG_FLAG1  6'd54
`define ABM_CFG_FLAG2  6'd55
`define ABM_WPAR_PAR0  6'd2
`define ABM_WPAR_LAST  6'd17
`define ABM_MODE_BIT   3
`define ABM_AUTO_BIT   3
`define ABM_LAST_SLV   5'd31

// reset values
`define ABM_PAR_RST    4'hF
`define ABM_MODE_RST   1'b0
`define ABM_AUTO_RST   1'b0

`endif

/* rtl/abm_pkg.sv */
/*
 types of the bus master job interpreter.
 assumes nothing of its surroundings.
*/
package abm_pkg;
	// job engine states
	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_USE, ST_CHK, ST_TX}
		abm_state_t;
	// one parameter transfer or one echo value
	typedef struct packed {
		logic       valid;
		logic [4:0] addr;
		logic [3:0] data;
	} abm_par_t;
endpackage

/* rtl/abm_mem.sv */
/*
 send buffer memory: one write port, one read port with registered data.
 assumes a single clock shared with the job engine.
*/
`timescale 1ns/1ps
`default_nettype none
module abm_mem (
	input  wire logic       clk,   // system clock
	input  wire logic       we,    // write strobe
	input  wire logic [5:0] waddr, // write byte index
	input  wire logic [7:0] wdata, // write byte
	input  wire logic [5:0] raddr, // read byte index
	output logic      [7:0] rdata  // registered read byte
);
	logic [7:0] mem [64]; // job bytes

	// write and registered read
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

/* rtl/abm_top.sv */
/*
 job interpreter of the actuator bus master: avalon register slave, send
 buffer, configuration, parameter write and echo jobs, parameter sender.
 assumes slave-side logic on the same clock answering PARAM_TX_READY and
 returning echoes on PARAM_ECHO.
*/
`timescale 1ns/1ps
`default_nettype none
`include "abm_regs.svh"
module abm_top (
	input  wire logic        CLK,               // 100 mhz clock
	input  wire logic        RESET_N,           // async reset, low
	input  wire logic [11:0] AVS_ADDRESS,       // byte address
	input  wire logic        AVS_READ,          // read request
	input  wire logic        AVS_WRITE,         // write request
	input  wire logic [31:0] AVS_WRITEDATA,     // write data
	output logic      [31:0] AVS_READDATA,      // read data
	output logic             AVS_WAITREQUEST,   // stall
	input  wire logic        PROTECTED_MODE,    // device runs protected
	input  wire logic        STARTUP,           // start-up pulse
	input  wire logic        PARAM_TX_READY,    // slave side takes param
	input  wire abm_pkg::abm_par_t PARAM_ECHO,  // echo from a slave
	output abm_pkg::abm_par_t      PARAM_TX,    // param to a slave
	output logic             CONFIG_MODE_START, // start in config mode
	output logic             AUTO_ADDR_ENABLE,  // auto addressing on
	output logic      [31:0] CONFIGURED_SLAVES  // configured_slave_list
);
	abm_pkg::abm_state_t st, next_st;   // engine state
	logic [5:0]  idx, next_idx;         // job byte index
	logic [4:0]  slv, next_slv;         // slave being sent
	logic        force_all, next_force; // send without compare
	logic        start_req, next_start; // job start pending
	logic        boot, next_boot;       // start-up send pending
	logic [7:0]  code, next_code;       // current job code
	logic        done, next_done;       // job finished
	logic        refused, next_refused; // refused in protected mode
	logic        unknown, next_unknown; // unknown code
	logic        mode, next_mode;       // start-up mode flag
	logic        auto_en, next_auto;    // auto address flag
	logic [31:0] list, next_list;       // configured slaves
	logic [31:0][7:0] cfg, next_cfg;    // id and io per slave
	logic [31:0][3:0] perm, next_perm;  // permanent parameters
	logic [31:0][3:0] pend, next_pend;  // parameters to send
	logic [31:0][3:0] act, next_act;    // actual parameters
	logic [31:0][3:0] rxe, next_rxe;    // echo response snapshot
	logic [31:0][3:0] echo;             // latest echo per slave
	abm_pkg::abm_par_t tx, next_tx;     // outgoing transfer
	logic [1:0]  ph, next_ph;           // bus access phase
	logic        wreq, next_wreq;       // waitrequest flop
	logic [31:0] rdat, next_rdat;       // read data flop
	logic [7:0]  sb_rdata;              // send buffer byte
	logic        busy;                  // engine working
	logic        wr_ok;                 // write taken this edge
	logic        ctrl_wr;               // start written
	logic        sb_we;                 // send buffer write
	logic [3:0]  pg;                    // address page
	logic [3:0]  rj;                    // response byte index
	logic [3:0]  pn;                    // packed pair index

	assign busy    = (st != abm_pkg::ST_IDLE);
	assign wr_ok   = AVS_WRITE && (ph == 2'd2);
	assign ctrl_wr = wr_ok && (AVS_ADDRESS == `ABM_REG_CTRL)
		&& AVS_WRITEDATA[0];
	assign pg      = AVS_ADDRESS[11:8];
	assign sb_we   = wr_ok && (pg == `ABM_PAGE_SBUF) && !busy;
	assign rj      = AVS_ADDRESS[5:2];

	// send buffer, read by bus when idle and by engine when busy
	abm_mem abm_mem_i (
		.clk   (CLK),
		.we    (sb_we),
		.waddr (AVS_ADDRESS[7:2]),
		.wdata (AVS_WRITEDATA[7:0]),
		.raddr (busy ? idx : AVS_ADDRESS[7:2]),
		.rdata (sb_rdata)
	);

	// bus slave: phase 0 request, 1 memory read, 2 answer
	always_comb begin
		next_ph   = 2'd0;
		next_wreq = 1'b1;
		next_rdat = rdat;
		if (AVS_READ || AVS_WRITE) begin
			next_ph   = (ph == 2'd2) ? 2'd0 : ph + 2'd1;
			next_wreq = (ph != 2'd1);
		end
		if ((ph == 2'd1) && AVS_READ) begin // read mux
			next_rdat = 32'h0000_0000;
			case (pg)
				4'h0: begin
					if (AVS_ADDRESS == `ABM_REG_STAT) begin
						next_rdat[5:0] = {auto_en, mode, unknown, refused,
							done, busy};
					end else if (AVS_ADDRESS == `ABM_REG_LIST) begin
						next_rdat = list;
					end else if (AVS_ADDRESS == `ABM_REG_CODE) begin
						next_rdat[7:0] = code;
					end
				end
				`ABM_PAGE_SBUF: next_rdat[7:0] = busy ? 8'h00 : sb_rdata;
				`ABM_PAGE_RBUF: begin // two echoes per byte
					if (AVS_ADDRESS[7:6] == 2'b00) begin
						next_rdat[7:0] = {(rj == 4'h0) ? 4'h0 :
							rxe[{rj, 1'b0}], rxe[{rj, 1'b1}]};
					end
				end
				`ABM_PAGE_CFG: begin
					if (!AVS_ADDRESS[7]) begin
						next_rdat[7:0] = cfg[AVS_ADDRESS[6:2]];
					end
				end
				default: next_rdat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ph   <= 2'd0;
			wreq <= 1'b1;
			rdat <= 32'h0000_0000;
		end else begin
			ph   <= next_ph;
			wreq <= next_wreq;
			rdat <= next_rdat;
		end
	end

	// echo capture, newest echo wins
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			echo <= '0;
		end else if (PARAM_ECHO.valid) begin
			echo[PARAM_ECHO.addr] <= PARAM_ECHO.data;
		end
	end

	// job engine next values
	always_comb begin
		next_st      = st;
		next_idx     = idx;
		next_slv     = slv;
		next_force   = force_all;
		next_start   = start_req || ctrl_wr; // set wins over take
		next_boot    = boot || STARTUP;
		next_code    = code;
		next_done    = done;
		next_refused = refused;
		next_unknown = unknown;
		next_mode    = mode;
		next_auto    = auto_en;
		next_list    = list;
		next_cfg     = cfg;
		next_perm    = perm;
		next_pend    = pend;
		next_act     = act;
		next_rxe     = rxe;
		next_tx      = tx;
		pn           = 4'h0;
		case (st)
			abm_pkg::ST_IDLE: begin
				if (boot) begin // resend permanent parameters
					next_boot  = STARTUP;
					next_pend  = perm;
					next_force = 1'b1;
					next_slv   = 5'd1;
					next_st    = abm_pkg::ST_CHK;
				end else if (start_req) begin
					next_start   = ctrl_wr;
					next_idx     = 6'd0;
					next_done    = 1'b0;
					next_refused = 1'b0;
					next_unknown = 1'b0;
					next_st      = abm_pkg::ST_RD;
				end
			end
			abm_pkg::ST_RD: next_st = abm_pkg::ST_USE;
			abm_pkg::ST_USE: begin
				next_st  = abm_pkg::ST_RD;
				next_idx = idx + 6'd1;
				if (idx == 6'd0) begin // job code
					next_code = sb_rdata;
					if (sb_rdata == `ABM_CODE_CFG && PROTECTED_MODE) begin
						next_refused = 1'b1;
						next_done    = 1'b1;
						next_st      = abm_pkg::ST_IDLE;
					end else if (sb_rdata == `ABM_CODE_ECHO) begin
						next_rxe  = echo;
						next_done = 1'b1;
						next_st   = abm_pkg::ST_IDLE;
					end else if (sb_rdata != `ABM_CODE_CFG
						&& sb_rdata != `ABM_CODE_WPAR) begin
						next_unknown = 1'b1;
						next_done    = 1'b1;
						next_st      = abm_pkg::ST_IDLE;
					end
				end else if (code == `ABM_CODE_CFG) begin
					if (idx >= `ABM_CFG_LIST0 && idx <= `ABM_CFG_LIST3) begin
						for (int k = 0; k < 8; k++) begin
							next_list[{idx[1:0] + 2'd2, 3'(k)}] =
								sb_rdata[7 - k];
						end
					end else if (idx <= `ABM_CFG_ID31
						&& idx >= `ABM_CFG_ID0) begin
						next_cfg[5'(idx - `ABM_CFG_ID0)] = sb_rdata;
					end else if (idx <= `ABM_CFG_PAR15
						&& idx >= `ABM_CFG_PAR0) begin
						pn = 4'(idx - `ABM_CFG_PAR0);
						if (pn != 4'h0) begin
							next_perm[{pn, 1'b0}] = sb_rdata[7:4];
						end
						next_perm[{pn, 1'b1}] = sb_rdata[3:0];
					end else if (idx == `ABM_CFG_FLAG1) begin
						next_mode = sb_rdata[`ABM_MODE_BIT];
					end else if (idx == `ABM_CFG_FLAG2) begin
						next_auto = sb_rdata[`ABM_AUTO_BIT];
						next_done = 1'b1;
						next_st   = abm_pkg::ST_IDLE;
					end
				end else if (idx >= `ABM_WPAR_PAR0) begin // parameter list
					pn = 4'(idx - `ABM_WPAR_PAR0);
					if (pn != 4'h0) begin
						next_pend[{pn, 1'b0}] = sb_rdata[7:4];
					end
					next_pend[{pn, 1'b1}] = sb_rdata[3:0];
					if (idx == `ABM_WPAR_LAST) begin
						next_slv   = 5'd1;
						next_force = 1'b0;
						next_st    = abm_pkg::ST_CHK;
					end
				end
			end
			abm_pkg::ST_CHK: begin
				if (force_all || pend[slv] != act[slv]) begin
					next_tx.valid = 1'b1;
					next_tx.addr  = slv;
					next_tx.data  = pend[slv];
					next_st       = abm_pkg::ST_TX;
				end else if (slv == `ABM_LAST_SLV) begin // unchanged
					next_done = 1'b1;
					next_st   = abm_pkg::ST_IDLE;
				end else begin
					next_slv = slv + 5'd1;
				end
			end
			abm_pkg::ST_TX: begin
				if (PARAM_TX_READY) begin // slave side took it
					next_tx.valid = 1'b0;
					next_act[slv] = pend[slv];
					next_slv      = slv + 5'd1;
					next_st       = abm_pkg::ST_CHK;
					if (slv == `ABM_LAST_SLV) begin
						next_done = 1'b1;
						next_st   = abm_pkg::ST_IDLE;
					end
				end
			end
			default: next_st = abm_pkg::ST_IDLE;
		endcase
	end

	// job engine registers
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st <= abm_pkg::ST_IDLE;
			idx <= 6'd0;
			slv <= 5'd1;
			force_all <= 1'b0;
			start_req <= 1'b0;
			boot <= 1'b0;
			code <= 8'h00;
			done <= 1'b0;
			refused <= 1'b0;
			unknown <= 1'b0;
			mode <= `ABM_MODE_RST;
			auto_en <= `ABM_AUTO_RST;
			list <= 32'h0000_0000;
			cfg <= '0;
			perm <= {32{`ABM_PAR_RST}};
			pend <= {32{`ABM_PAR_RST}};
			act <= {32{`ABM_PAR_RST}};
			rxe <= '0;
			tx <= '0;
		end else begin
			st <= next_st;
			idx <= next_idx;
			slv <= next_slv;
			force_all <= next_force;
			start_req <= next_start;
			boot <= next_boot;
			code <= next_code;
			done <= next_done;
			refused <= next_refused;
			unknown <= next_unknown;
			mode <= next_mode;
			auto_en <= next_auto;
			list <= next_list;
			cfg <= next_cfg;
			perm <= next_perm;
			pend <= next_pend;
			act <= next_act;
			rxe <= next_rxe;
			tx <= next_tx;
		end
	end

	assign AVS_READDATA      = rdat;
	assign AVS_WAITREQUEST   = wreq;
	assign PARAM_TX          = tx;
	assign CONFIG_MODE_START = mode;
	assign AUTO_ADDR_ENABLE  = auto_en;
	assign CONFIGURED_SLAVES = list;

	// checks next to the engine
	property p_refuse;
		@(posedge CLK) disable iff (!RESET_N)
		(st == abm_pkg::ST_USE && idx == 6'd0 && PROTECTED_MODE
		&& sb_rdata == `ABM_CODE_CFG) |=> (refused && !busy) ##1 $stable(list);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("cfg job not refused");
	property p_mode;
		@(posedge CLK) disable iff (!RESET_N)
		(st == abm_pkg::ST_USE && code == `ABM_CODE_CFG
		&& idx == `ABM_CFG_FLAG1) |=> CONFIG_MODE_START == $past(sb_rdata[3]);
	endproperty
	a_mode: assert property (p_mode)
		else $error("start mode not taken");
	property p_auto;
		@(posedge CLK) disable iff (!RESET_N)
		(st == abm_pkg::ST_USE && code == `ABM_CODE_CFG
		&& idx == `ABM_CFG_FLAG2) |=> AUTO_ADDR_ENABLE == $past(sb_rdata[3]);
	endproperty
	a_auto: assert property (p_auto)
		else $error("auto flag not taken");
	property p_keep;
		@(posedge CLK) disable iff (!RESET_N)
		(st != abm_pkg::ST_USE) |=> $stable(mode) && $stable(auto_en);
	endproperty
	a_keep: assert property (p_keep)
		else $error("flag changed outside job");
	property p_changed;
		@(posedge CLK) disable iff (!RESET_N)
		$rose(tx.valid) |-> force_all || tx.data != act[tx.addr];
	endproperty
	a_changed: assert property (p_changed)
		else $error("unchanged param sent");
	property p_echo;
		@(posedge CLK) disable iff (!RESET_N)
		PARAM_ECHO.valid |=> echo[$past(PARAM_ECHO.addr)]
			== $past(PARAM_ECHO.data);
	endproperty
	a_echo: assert property (p_echo)
		else $error("echo not stored");
	property p_resp;
		@(posedge CLK) disable iff (!RESET_N)
		(st == abm_pkg::ST_USE && idx == 6'd0
		&& sb_rdata == `ABM_CODE_ECHO) |=> rxe == $past(echo) && done;
	endproperty
	a_resp: assert property (p_resp)
		else $error("echo list not copied");
	property p_unknown;
		@(posedge CLK) disable iff (!RESET_N)
		(st == abm_pkg::ST_USE && idx == 6'd0 && sb_rdata != `ABM_CODE_CFG
		&& sb_rdata != `ABM_CODE_WPAR && sb_rdata != `ABM_CODE_ECHO)
		|=> unknown && !busy;
	endproperty
	a_unknown: assert property (p_unknown)
		else $error("bad code not rejected");
	property p_boot;
		@(posedge CLK) disable iff (!RESET_N)
		(st == abm_pkg::ST_IDLE && boot) |=> force_all && pend == perm
			##[1:2] tx.valid;
	endproperty
	a_boot: assert property (p_boot)
		else $error("start-up send missing");
endmodule
`default_nettype wire

/* sim/abm_slave_model.sv */
/*
 slave side model: takes parameter transfers and answers with echoes.
 assumes the job interpreter's clock and reset; echo is inverted data.
*/
`timescale 1ns/1ps
`default_nettype none
module abm_slave_model (
	input  wire logic              clk,   // system clock
	input  wire logic              rst_n, // async reset, low
	input  wire logic [3:0]        stall, // wait cycles before ready
	input  wire abm_pkg::abm_par_t tx,    // transfer from device
	output logic                   ready, // takes transfer at edge
	output abm_pkg::abm_par_t      echo,  // echo back to device
	output logic [7:0]             n_tx   // transfers taken
);
	logic [3:0] wait_cnt; // cycles waited on this transfer
	// accept after stall cycles, echo one cycle after acceptance
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
			echo <= '0;
			n_tx <= 8'h00;
			wait_cnt <= 4'h0;
		end else if (tx.valid && ready) begin
			// transfer taken, slave answers with its echo
			ready <= 1'b0;
			wait_cnt <= 4'h0;
			n_tx <= n_tx + 8'h01;
			echo <= {1'b1, tx.addr, ~tx.data};
		end else begin
			// idle echo lines toggle so no stale value shows
			echo <= {1'b0, ~echo.addr, ~echo.data};
			if (tx.valid && wait_cnt == stall) begin
				ready <= 1'b1;
			end else if (tx.valid) begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* sim/actuator_bus_master_config_jobs_bench.sv */
/*
 testbench of the job interpreter: avalon tasks, job sequences, checks.
 assumes abm_pkg, abm_regs.svh and the slave model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "abm_regs.svh"
module actuator_bus_master_config_jobs_bench;
	logic              clk = 1'b0;       // system clock
	logic              rst_n = 1'b0;     // async reset, low
	logic [11:0]       avs_address = '0; // bus address
	logic              avs_read = 1'b0;  // bus read
	logic              avs_write = 1'b0; // bus write
	logic [31:0]       avs_writedata = '0; // bus write data
	logic [31:0]       avs_readdata;     // bus read data
	logic              avs_waitrequest;  // bus stall
	logic              prot = 1'b0;      // protected mode
	logic              startup = 1'b0;   // start-up pulse
	logic [3:0]        stall = 4'h0;     // slave wait cycles
	logic              ready;            // slave takes transfer
	abm_pkg::abm_par_t echo;             // echo from slave
	abm_pkg::abm_par_t tx;               // transfer to slave
	logic              mode;             // start in config mode
	logic              auto;             // auto addressing
	logic [31:0]       slaves;           // configured slave list
	logic [7:0]        n_tx;             // transfers seen
	logic [31:0]       q;                // last read data
	logic [7:0]        base_tx;          // transfers before a job
	logic [7:0]        jb [64];          // job image
	logic [3:0]        ex [32];          // expected echoes
	int                n_fail = 0;       // mismatches
	int                comparisons = 0;  // checks made
	// free running 100 mhz clock
	always #5 clk = ~clk;
	abm_top abm_top_i (.CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write),
		.AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .PROTECTED_MODE(prot),
		.STARTUP(startup), .PARAM_TX_READY(ready), .PARAM_ECHO(echo),
		.PARAM_TX(tx), .CONFIG_MODE_START(mode), .AUTO_ADDR_ENABLE(auto),
		.CONFIGURED_SLAVES(slaves));
	abm_slave_model abm_slave_model_i (.clk(clk), .rst_n(rst_n),
		.stall(stall), .tx(tx), .ready(ready), .echo(echo), .n_tx(n_tx));
	// verdict and end of run
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// report one mismatch
	task automatic fail(input string m);
		$display("[ERR] %0t %s", $time, m);
		n_fail++;
	endtask
	// compare one value
	task automatic chk(input logic [31:0] got, exp, input string m);
		comparisons++;
		if (got !== exp) fail(m);
	endtask
	// one avalon access, held until waitrequest sampled low
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 50) begin
			fail("bus timeout");
			print_verdict();
		end
	endtask
	// load n job bytes, start, poll until the job has ended
	task automatic run_job(input int n);
		int i;
		for (i = 0; i < n; i++) bus(1'b1, 12'h100 + 12'(4 * i), {24'h0, jb[i]});
		bus(1'b1, `ABM_REG_CTRL, 32'h1);
		for (i = 0; i < 500; i++) begin
			bus(1'b0, `ABM_REG_STAT, 32'h0);
			if (q[0] === 1'b0 && q[3:1] !== 3'b000) break;
		end
		if (i == 500) begin
			fail("job timeout");
			print_verdict();
		end
	endtask
	// start-up pulse; all 31 permanent parameters p go out
	task automatic start_up(input logic [3:0] p);
		int i;
		logic [7:0] base;
		base = n_tx;
		@(posedge clk);
		startup <= 1'b1;
		@(posedge clk);
		startup <= 1'b0;
		for (i = 0; i < 2000 && n_tx !== base + 8'd31; i++) @(posedge clk);
		if (i == 2000) begin
			fail("startup timeout");
			print_verdict();
		end
		repeat (20) @(posedge clk);
		chk(32'(n_tx - base), 32'd31, "startup count");
		for (i = 1; i < 32; i++) ex[i] = ~p;
		$display("test startup done");
	endtask
	// configuration job image with given flag bytes
	task automatic fill_cfg(input logic [7:0] f1, f2);
		int i;
		for (i = 0; i < 64; i++) jb[i] = 8'h55;
		for (i = 0; i < 32; i++) jb[6 + i] = 8'(i * 7 + 3);
		jb[0] = `ABM_CODE_CFG;
		jb[2] = 8'h80;
		jb[3] = 8'h00;
		jb[4] = 8'h00;
		jb[5] = 8'h01;
		jb[54] = f1;
		jb[55] = f2;
	endtask
	// main sequence
	initial begin
		for (int i = 0; i < 32; i++) ex[i] = 4'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// reset values and unmapped place
		bus(1'b0, `ABM_REG_STAT, 32'h0);
		chk(q, 32'h0, "stat reset");
		bus(1'b1, 12'h0F0, 32'hFF);
		bus(1'b0, 12'h0F0, 32'h0);
		chk(q, 32'h0, "unmapped read");
		chk(slaves, 32'h0, "list reset");
		$display("test reset done");
		start_up(`ABM_PAR_RST);
		// configuration refused while protected
		fill_cfg(8'hFF, 8'hF7);
		prot <= 1'b1;
		run_job(56);
		chk({31'h0, q[2]}, 32'h1, "not refused");
		chk(slaves, 32'h0, "list stored when protected");
		prot <= 1'b0;
		// accepted: list, id/io, flags; other flag bits ignored
		run_job(56);
		chk(slaves, 32'h8000_0001, "list");
		chk({30'h0, mode, auto}, 32'h2, "flags one");
		chk({26'h0, q[5:4]}, 32'h1, "stat flags");
		for (int n = 0; n < 32; n += 17) begin
			bus(1'b0, 12'h300 + 12'(4 * n), 32'h0);
			chk(q, {24'h0, jb[6 + n]}, "id io");
		end
		fill_cfg(8'hF7, 8'h08);
		run_job(56);
		chk({30'h0, mode, auto}, 32'h1, "flags two");
		$display("test config done");
		// stored permanent parameters go out at start-up, slow slave
		stall <= 4'h3;
		start_up(4'h5);
		// write parameters: only slaves 3 and 30 differ
		stall <= 4'h2;
		for (int i = 0; i < 64; i++) jb[i] = 8'h55;
		jb[0] = `ABM_CODE_WPAR;
		jb[3] = 8'h5A;
		jb[17] = 8'h25;
		base_tx = n_tx;
		run_job(18);
		repeat (10) @(posedge clk);
		chk(32'(n_tx - base_tx), 32'd2, "changed only");
		ex[3] = 4'h5;
		ex[30] = 4'hD;
		$display("test write params done");
		// echo list in one response, newest echo per slave
		jb[0] = `ABM_CODE_ECHO;
		run_job(1);
		for (int j = 0; j < 16; j++) begin
			bus(1'b0, 12'h200 + 12'(4 * j), 32'h0);
			chk(q, {24'h0, ex[2 * j], ex[2 * j + 1]}, "echo");
		end
		$display("test echo done");
		// unknown job code
		jb[0] = 8'h55;
		run_job(1);
		chk({31'h0, q[3]}, 32'h1, "unknown code");
		bus(1'b0, `ABM_REG_CODE, 32'h0);
		chk(q, 32'h55, "last code");
		$display("test unknown done");
		print_verdict();
	end
endmodule
`default_nettype wire
